/* File: hw/sfp_pkg.sv */
package sfp_pkg;
  localparam int ADDR_W     = 24;
  localparam int PAGE_W     = 8;
  localparam int SECTOR_LSB = 16;
  localparam int CNT_W      = 5;
  localparam int SYNC_W     = 6;

  localparam logic [CNT_W-1:0]  ADDR_BITS = 5'h18;
  localparam logic [CNT_W-1:0]  BYTE_BITS = 5'h08;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [SYNC_W-1:0] SYNC_RST  = 6'h10;
  localparam logic [PAGE_W-1:0] PAGE_LAST = 8'hFF;

  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_DOFR  = 8'h3B;
  localparam logic [7:0] OP_DIOFR = 8'hBB;
  localparam logic [7:0] OP_QOFR  = 8'h6B;
  localparam logic [7:0] OP_QIOFR = 8'hEB;
  localparam logic [7:0] OP_WREN  = 8'h06;

  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;

  localparam logic [2:0] LANE_1 = 3'h1;
  localparam logic [2:0] LANE_2 = 3'h2;
  localparam logic [2:0] LANE_4 = 3'h4;

  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;

  localparam int FSR_READY     = 7;
  localparam int FSR_PROG_FAIL = 4;
  localparam int FSR_PROG_SUSP = 2;
  localparam int FSR_PROT      = 1;

  localparam int CLK_PERIOD_NS          = 5;
  localparam int PAGE_PROGRAM_TIME_NS   = 5000000;
  localparam int PROG_TIMEOUT_CYCLES    =
    PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_DONE8, ST_IGNORE
  } sfp_state_t;

  typedef enum logic [1:0] {PG_IDLE, PG_LOAD, PG_WRITE} sfp_pstate_t;
endpackage : sfp_pkg

/* File: hw/sfp_link_sync.sv */
`timescale 1ns/10ps
module sfp_link_sync (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       sclkPin,
  input  wire logic       csNPin,
  input  wire logic [3:0] dqPin,
  output logic            sclkRise,
  output logic            sclkFall,
  output logic            csNS,
  output logic            csRise,
  output logic [3:0]      dqS
);
  import sfp_pkg::*;

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic [1:0]        prev_reg;

  // Edges are found on the second stage only, never on the first.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
      prev_reg <= SYNC_RST[SYNC_W-1:SYNC_W-2];
    end else begin
      meta_reg <= {sclkPin, csNPin, dqPin};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[SYNC_W-1:SYNC_W-2];
    end
  end

  assign sclkRise = sync_reg[5] & ~prev_reg[1];
  assign sclkFall = ~sync_reg[5] & prev_reg[1];
  assign csNS     = sync_reg[4];
  assign csRise   = sync_reg[4] & ~prev_reg[0];
  assign dqS      = sync_reg[3:0];
endmodule : sfp_link_sync

/* File: hw/sfp_page_buf.sv */
`timescale 1ns/10ps
module sfp_page_buf (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      clr,
  input  wire logic                      wrEn,
  input  wire logic [sfp_pkg::PAGE_W-1:0] wrIdx,
  input  wire logic [7:0]                wrData,
  input  wire logic [sfp_pkg::PAGE_W-1:0] rdIdx,
  output logic [7:0]                     rdData,
  output logic                           rdValid
);
  import sfp_pkg::*;

  logic [7:0]             mem [2**PAGE_W];
  logic [2**PAGE_W-1:0]   valid_reg;

  // A later byte to the same slot overwrites the earlier one, so only
  // the last page-worth of bytes survives.
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      valid_reg <= '0;
      rdValid   <= 1'b0;
    end else begin
      if (clr) begin
        valid_reg <= '0;
      end else if (wrEn) begin
        valid_reg[wrIdx] <= 1'b1;
      end
      rdValid <= valid_reg[rdIdx];
    end
  end
endmodule : sfp_page_buf

/* File: hw/sfp_flash_seq.sv */
`timescale 1ns/10ps
// Functional notes
// R1: All read and program addresses are 24 bits wide.
// R2: Read frame is chip select low, opcode, three address bytes.
// R3: Read address increments after every byte shifted out.
// R4: Chip select high aborts a read and releases data lanes.
// R5: Read opcodes 03, 0B, 3B, BB, 6B and EB are decoded.
// R6: Extended protocol lane use follows each read opcode.
// R7: Dual and quad protocols accept their subset, all phases wide.
// R8: Fast reads insert dummy clocks between address and data.
// R9: Host sets write enable first and ends on a byte boundary.
// R10: Program frame is opcode, address, then one or more bytes.
// R11: Programming starts on chip select rise after a good frame.
// R12: Bytes past page end wrap to the start of the same page.
// R13: Over-long bursts keep only the last page of bytes.
// R14: Short bursts program only the addressed bytes.
// R15: Write in progress is high while programming runs.
// R16: Write enable latch clears when programming ends.
// R17: Suspend pauses programming and resume continues it.
// R18: Timeout clears write enable and sets program fail.
// R19: Bad frame end executes nothing and keeps write enable.
// R20: Protected target: no program, flag bits one and four set.
// R21: Program lane use follows each program opcode.
// R22: Program forms are accepted per protocol subset.
// R23: Write enable opcode 06 stands alone in its frame.
// R24: Page is 256 bytes, low eight address bits index it.
// R25: Bits go most significant first, top lane carries the MSB.
module sfp_flash_seq #(
  parameter logic [7:0]  OP_PAGE_PROG  = 8'h02,
  parameter logic [7:0]  OP_DUAL_PROG  = 8'hA2,
  parameter logic [7:0]  OP_XDUAL_PROG = 8'hD2,
  parameter logic [7:0]  OP_QUAD_PROG  = 8'h32,
  parameter logic [7:0]  OP_XQUAD_PROG = 8'h12,
  parameter logic [7:0]  OP_SUSPEND    = 8'h75,
  parameter logic [7:0]  OP_RESUME     = 8'h7A,
  parameter int unsigned PROG_TIMEOUT  = sfp_pkg::PROG_TIMEOUT_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       sclkPin,
  input  wire logic                       csNPin,
  input  wire logic [3:0]                 dqIn,
  output logic [3:0]                      dqOut,
  output logic [3:0]                      dqOe,
  input  wire logic [1:0]                 protocolSel,
  input  wire logic [3:0]                 dummyCycles,
  input  wire logic [255:0]               sectorLock,
  input  wire logic                       clearFlags,
  output logic                            writeInProgress,
  output logic                            writeEnableLatch,
  output logic [7:0]                      flagStatus,
  output logic [sfp_pkg::ADDR_W-1:0]      memRdAddr,
  input  wire logic [7:0]                 memRdData,
  output logic                            memWrEn,
  output logic [sfp_pkg::ADDR_W-1:0]      memWrAddr,
  output logic [7:0]                      memWrData,
  input  wire logic                       memWrReady
);
  import sfp_pkg::*;

  logic              sclkRise, sclkFall, csNS, csRise;
  logic [3:0]        dqS;
  sfp_state_t        state_reg;
  logic [ADDR_W-1:0] inSh_reg, addr_reg, shNext;
  logic [ADDR_W-1:0] cmdSh;
  logic [7:0]        op_reg, decOp, outSh_reg, outShNext, bufData;
  logic [CNT_W-1:0]  cnt_reg, outCnt_reg;
  logic              gotByte_reg, wel_reg, fail_reg, prot_reg, susp_reg;
  logic [3:0]        dqOut_reg, dqOe_reg;
  sfp_pstate_t       pst_reg;
  logic [PAGE_W-1:0] idx_reg;
  logic [ADDR_W-PAGE_W-1:0] page_reg;
  logic [31:0]       timer_reg;
  logic [2:0]        pw, aw, dw, curW;
  logic              isRead, isProg, isFast, opOk, ctlOp, lastBits;
  logic              wip, busyRun, bufWr, bufClr, bufValid, locked;
  logic              goodEnd, progStart, protHit, welSet, suspCmd;
  logic              resumeCmd, advance, progDone, timeoutNow;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  function automatic logic [ADDR_W-1:0] shiftIn(
    input logic [ADDR_W-1:0] v, input logic [3:0] d, input logic [2:0] w);
    unique case (w)
      LANE_2:  shiftIn = {v[ADDR_W-3:0], d[1:0]};
      LANE_4:  shiftIn = {v[ADDR_W-5:0], d};
      default: shiftIn = {v[ADDR_W-2:0], d[0]};
    endcase
  endfunction : shiftIn

  // Single-lane data leaves on lane 1, dual data on lanes 0 and 1, quad data on all four.
  function automatic logic [3:0] laneMap(
    input logic [7:0] v, input logic [2:0] w);
    unique case (w)
      LANE_2:  laneMap = {2'h0, v[7:6]};
      LANE_4:  laneMap = v[7:4];
      default: laneMap = {2'h0, v[7], 1'b0};
    endcase
  endfunction : laneMap

  sfp_link_sync uSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .sclkPin  (sclkPin),
    .csNPin   (csNPin),
    .dqPin    (dqIn),
    .sclkRise (sclkRise),
    .sclkFall (sclkFall),
    .csNS     (csNS),
    .csRise   (csRise),
    .dqS      (dqS)
  );

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode; during the opcode phase it looks at the byte being
  // completed so the next phase is chosen on the same edge.
  always_comb begin
    unique case (protocolSel)
      PROTO_DUAL: pw = LANE_2;
      PROTO_QUAD: pw = LANE_4;
      default:    pw = LANE_1;
    endcase
    // The opcode view uses the command width directly, which keeps the
    // decode free of a loop through the lane width that it selects.
    cmdSh  = shiftIn(inSh_reg, dqS, pw);
    decOp  = (state_reg == ST_CMD) ? cmdSh[7:0] : op_reg;
    isRead = 1'b0;
    isProg = 1'b0;
    isFast = 1'b1;
    opOk   = 1'b0;
    aw     = LANE_1;
    dw     = LANE_1;
    case (decOp) // R5 R6 R21
      OP_READ:  begin isRead = 1'b1; isFast = 1'b0; opOk = pw == LANE_1; end
      OP_FAST:  begin isRead = 1'b1; opOk = 1'b1; end
      OP_DOFR:  begin isRead = 1'b1; dw = LANE_2; opOk = pw != LANE_4; end
      OP_DIOFR: begin
        isRead = 1'b1; aw = LANE_2; dw = LANE_2; opOk = pw != LANE_4;
      end
      OP_QOFR:  begin isRead = 1'b1; dw = LANE_4; opOk = pw != LANE_2; end
      OP_QIOFR: begin
        isRead = 1'b1; aw = LANE_4; dw = LANE_4; opOk = pw != LANE_2;
      end
      OP_PAGE_PROG:  begin isProg = 1'b1; opOk = 1'b1; end // R22
      OP_DUAL_PROG:  begin isProg = 1'b1; dw = LANE_2; opOk = pw != LANE_4; end
      OP_XDUAL_PROG: begin
        isProg = 1'b1; aw = LANE_2; dw = LANE_2; opOk = pw != LANE_4;
      end
      OP_QUAD_PROG:  begin isProg = 1'b1; dw = LANE_4; opOk = pw != LANE_2; end
      OP_XQUAD_PROG: begin
        isProg = 1'b1; aw = LANE_4; dw = LANE_4; opOk = pw != LANE_2;
      end
      default: ;
    endcase
    if (pw != LANE_1) begin // R7
      aw = pw;
      dw = pw;
    end
    unique case (state_reg)
      ST_CMD:   curW = pw;
      ST_ADDR:  curW = aw;
      ST_DUMMY: curW = LANE_1;
      default:  curW = dw;
    endcase
  end

  assign wip      = pst_reg != PG_IDLE;
  assign busyRun  = wip & ~susp_reg;
  assign ctlOp    = (decOp == OP_WREN && !wip) ||
                    (decOp == OP_SUSPEND && busyRun) ||
                    (decOp == OP_RESUME && susp_reg);
  assign shNext   = shiftIn(inSh_reg, dqS, curW); // R25
  assign lastBits = cnt_reg == {2'h0, curW};

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer on synchronised serial clock edges.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_CMD;
      cnt_reg     <= BYTE_BITS;
      inSh_reg    <= '0;
      op_reg      <= '0;
      addr_reg    <= '0;
      gotByte_reg <= 1'b0;
    end else if (csNS) begin
      state_reg   <= ST_CMD;
      cnt_reg     <= BYTE_BITS;
      gotByte_reg <= 1'b0;
    end else if (sclkRise) begin // R2 R10
      inSh_reg <= shNext;
      cnt_reg  <= cnt_reg - {2'h0, curW};
      unique case (state_reg)
        ST_CMD: if (lastBits) begin
          op_reg  <= shNext[7:0];
          cnt_reg <= ADDR_BITS; // R1
          if (opOk && ((isRead && !busyRun) || (isProg && !wip)))
            state_reg <= ST_ADDR;
          else if (ctlOp)
            state_reg <= ST_DONE8;
          else
            state_reg <= ST_IGNORE;
        end
        ST_ADDR: if (lastBits) begin
          addr_reg <= shNext;
          if (isProg) begin
            state_reg <= ST_WDATA;
            cnt_reg   <= BYTE_BITS;
          end else if (isFast && dummyCycles != 4'h0) begin // R8
            state_reg <= ST_DUMMY;
            cnt_reg   <= {1'b0, dummyCycles};
          end else begin
            state_reg <= ST_RDATA;
          end
        end
        ST_DUMMY: if (lastBits) state_reg <= ST_RDATA;
        ST_WDATA: if (lastBits) begin
          // Only the byte index moves, so the page never changes.
          addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 8'h01; // R12 R13
          cnt_reg     <= BYTE_BITS;
          gotByte_reg <= 1'b1;
        end
        ST_DONE8: state_reg <= ST_IGNORE; // R23
        ST_RDATA, ST_IGNORE: ;
      endcase
    end else if (sclkFall && state_reg == ST_RDATA &&
                 outCnt_reg == CNT_ZERO) begin
      addr_reg <= addr_reg + 24'h000001; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data out: a new byte is fetched on the falling edge after the
  // last group of the previous one. The memory must answer within the
  // few core cycles that separate an address change from that edge.
  assign outShNext = (outCnt_reg == CNT_ZERO) ? memRdData
                                              : outSh_reg << dw;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outSh_reg  <= '0;
      outCnt_reg <= CNT_ZERO;
      dqOut_reg  <= '0;
      dqOe_reg   <= OE_NONE;
    end else if (csNS || state_reg != ST_RDATA) begin // R4
      outCnt_reg <= CNT_ZERO;
      dqOe_reg   <= OE_NONE;
    end else if (sclkFall) begin
      outSh_reg <= outShNext;
      dqOut_reg <= laneMap(outShNext, dw); // R6 R25
      if (outCnt_reg == CNT_ZERO) begin
        outCnt_reg <= BYTE_BITS - {2'h0, dw};
        dqOe_reg   <= (dw == LANE_1) ? OE_SINGLE :
                      (dw == LANE_2) ? OE_DUAL : OE_QUAD;
      end else begin
        outCnt_reg <= outCnt_reg - {2'h0, dw};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame-end decisions, taken on the chip select rise; page buffer strobes, taken on serial clock rises.
  assign goodEnd   = state_reg == ST_WDATA && cnt_reg == BYTE_BITS &&
                     gotByte_reg; // R19
  assign locked    = sectorLock[addr_reg[ADDR_W-1:SECTOR_LSB]];
  assign progStart = csRise && goodEnd && wel_reg && !locked; // R9 R11
  assign protHit   = csRise && goodEnd && wel_reg && locked; // R20
  assign welSet    = csRise && state_reg == ST_DONE8 && op_reg == OP_WREN;
  assign suspCmd   = csRise && state_reg == ST_DONE8 &&
                     op_reg == OP_SUSPEND && busyRun;
  assign resumeCmd = csRise && state_reg == ST_DONE8 &&
                     op_reg == OP_RESUME && susp_reg;
  assign bufWr  = !csNS && sclkRise && state_reg == ST_WDATA && lastBits;
  assign bufClr = !csNS && sclkRise && state_reg == ST_ADDR && lastBits &&
                  isProg;

  sfp_page_buf uBuf (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clr      (bufClr),
    .wrEn     (bufWr),
    .wrIdx    (addr_reg[PAGE_W-1:0]),
    .wrData   (shNext[7:0]),
    .rdIdx    (idx_reg),
    .rdData   (bufData),
    .rdValid  (bufValid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Self-timed program engine: walks the page and writes only slots
  // that were loaded, so untouched bytes keep their contents.
  assign advance    = pst_reg == PG_WRITE && !susp_reg &&
                      (!bufValid || memWrReady);
  assign progDone   = advance && idx_reg == PAGE_LAST;
  assign timeoutNow = busyRun && timer_reg == 32'(PROG_TIMEOUT - 1);
  assign memWrEn    = pst_reg == PG_WRITE && !susp_reg && bufValid; // R14
  assign memWrAddr  = {page_reg, idx_reg};
  assign memWrData  = bufData;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pst_reg   <= PG_IDLE;
      idx_reg   <= '0;
      page_reg  <= '0;
      timer_reg <= '0;
    end else begin
      if (busyRun) timer_reg <= timer_reg + 32'h00000001; // R17
      unique case (pst_reg)
        PG_IDLE: if (progStart) begin
          pst_reg   <= PG_LOAD;
          idx_reg   <= '0;
          page_reg  <= addr_reg[ADDR_W-1:PAGE_W]; // R24
          timer_reg <= '0;
        end
        PG_LOAD: if (!susp_reg) pst_reg <= PG_WRITE;
        PG_WRITE: if (advance) begin
          pst_reg <= progDone ? PG_IDLE : PG_LOAD;
          idx_reg <= idx_reg + 8'h01;
        end
      endcase
      if (timeoutNow) pst_reg <= PG_IDLE; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status bits. Hardware sets win over a clear in the same cycle, except the write enable latch, where the clear wins.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wel_reg  <= 1'b0;
      fail_reg <= 1'b0;
      prot_reg <= 1'b0;
      susp_reg <= 1'b0;
    end else begin
      if (progDone || timeoutNow) wel_reg <= 1'b0; // R16 R18
      else if (welSet) wel_reg <= 1'b1;
      if (timeoutNow || protHit) fail_reg <= 1'b1; // R18 R20
      else if (clearFlags) fail_reg <= 1'b0;
      if (protHit) prot_reg <= 1'b1;
      else if (clearFlags) prot_reg <= 1'b0;
      if (suspCmd) susp_reg <= 1'b1; // R17
      else if (resumeCmd || progDone || timeoutNow) susp_reg <= 1'b0;
    end
  end

  always_comb begin
    flagStatus                = '0;
    flagStatus[FSR_READY]     = !wip || susp_reg;
    flagStatus[FSR_PROG_FAIL] = fail_reg;
    flagStatus[FSR_PROG_SUSP] = susp_reg;
    flagStatus[FSR_PROT]      = prot_reg;
  end

  assign writeInProgress  = wip; // R15
  assign writeEnableLatch = wel_reg;
  assign memRdAddr        = addr_reg;
  assign dqOut            = dqOut_reg;
  assign dqOe             = dqOe_reg;

  ////////////////////////////////////////////////////////////////////////
  sequence s_byteOut;
    sclkFall && !csNS && state_reg == ST_RDATA && outCnt_reg == CNT_ZERO;
  endsequence
  sequence s_badEnd;
    csRise && state_reg == ST_WDATA && !goodEnd && wel_reg;
  endsequence

  property p_addr_step;
    s_byteOut |=> addr_reg == $past(addr_reg) + 24'h000001;
  endproperty
  a_addr_step: assert property (p_addr_step) // R3
    else $error("read address did not step after a byte");

  property p_cs_release;
    csRise |=> dqOe == OE_NONE ##1 dqOe == OE_NONE;
  endproperty
  a_cs_release: assert property (p_cs_release) // R4
    else $error("data lanes still driven after chip select rise");

  property p_bad_end;
    s_badEnd |=> wel_reg && !prot_reg && !fail_reg &&
                 pst_reg == $past(pst_reg);
  endproperty
  a_bad_end: assert property (p_bad_end) // R19
    else $error("misaligned program end changed state");

  property p_prot;
    protHit |=> wel_reg && flagStatus[FSR_PROT] &&
                flagStatus[FSR_PROG_FAIL] && !wip;
  endproperty
  a_prot: assert property (p_prot) // R20
    else $error("protected program not refused correctly");

  property p_start;
    progStart |=> writeInProgress ##1 writeInProgress;
  endproperty
  a_start: assert property (p_start) // R11
    else $error("program did not start on good frame end");

  property p_end_wel;
    $fell(writeInProgress) |-> !writeEnableLatch;
  endproperty
  a_end_wel: assert property (p_end_wel) // R16
    else $error("write enable latch kept after program end");

  property p_timeout;
    timeoutNow |=> !wel_reg && fail_reg && !wip;
  endproperty
  a_timeout: assert property (p_timeout) // R18
    else $error("timeout did not fail the program");

  property p_susp;
    susp_reg && $past(susp_reg) |-> $stable(timer_reg) && !memWrEn;
  endproperty
  a_susp: assert property (p_susp) // R17
    else $error("program advanced while suspended");

  property p_wrap;
    bufWr && addr_reg[PAGE_W-1:0] == PAGE_LAST |=>
      addr_reg[PAGE_W-1:0] == '0 &&
      addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]);
  endproperty
  a_wrap: assert property (p_wrap) // R12
    else $error("program data spilled into next page");
endmodule : sfp_flash_seq

/* File: verification/sfp_host_model.sv */
`timescale 1ns/10ps
module sfp_host_model (
  output logic       sclk,
  output logic       csN,
  output logic [3:0] dq,
  input  wire logic [3:0] dqW
);
  logic [7:0] rx;
  int         lanes = 1;

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    dq   = 4'hA;
    rx   = 8'h00;
  end

  ////////////////////////////////////////
  // The lead time keeps chip select well ahead of the first clock rise.
  task automatic start();
    csN = 1'b0;
    #32;
  endtask : start

  // Released lanes flip, so a stale level can never pass for fresh data.
  task automatic stop();
    #32;
    csN = 1'b1;
    dq  = ~dq;
    #200;
  endtask : stop

  // The serial clock only runs inside frames and idles low.
  task automatic bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      dq = {~dq[3:1], v[i]};
      #32;
      sclk = 1'b1;
      if (lanes == 4) rx = {rx[3:0], dqW};
      else if (lanes == 2) rx = {rx[5:0], dqW[1:0]};
      else rx = {rx[6:0], dqW[1]};
      #32;
      sclk = 1'b0;
    end
  endtask : bits
endmodule : sfp_host_model

/* File: verification/serial_flash_read_program_cmds_bench.sv */
`timescale 1ns/10ps
module serial_flash_read_program_cmds_bench;
  import sfp_pkg::*;
  logic              core_clk, rstn, sclk, csN, clearFlags;
  logic              memWrReady, memWrEn, wip, wel;
  logic [3:0]        hDq, dqIn, dqOut, dqOe;
  logic [7:0]        fsr, memRdData, memWrData;
  logic [ADDR_W-1:0] memRdAddr, memWrAddr;
  logic [255:0]      sectorLock;
  logic [7:0]        mem [0:131071];
  int                err_count, checks;

  assign dqIn      = (dqOe & dqOut) | (~dqOe & hDq);
  assign memRdData = mem[memRdAddr[16:0]];
  always @(posedge core_clk) begin
    if (memWrEn && memWrReady) mem[memWrAddr[16:0]] <= memWrData;
  end

  sfp_host_model sfp_host_model_i (
    .sclk(sclk), .csN(csN), .dq(hDq), .dqW(dqIn));

  sfp_flash_seq #(.PROG_TIMEOUT(600)) sfp_flash_seq_i (
    .core_clk(core_clk), .rstn(rstn), .sclkPin(sclk), .csNPin(csN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .protocolSel(PROTO_EXT),
    .dummyCycles(4'h8), .sectorLock(sectorLock), .clearFlags(clearFlags),
    .writeInProgress(wip), .writeEnableLatch(wel), .flagStatus(fsr),
    .memRdAddr(memRdAddr), .memRdData(memRdData), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .memWrReady(memWrReady));

  ////////////////////////////////////////
  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat

  task automatic cmp(input logic [7:0] got, exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp

  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic frame(input logic [7:0] op, input logic [23:0] a);
    sfp_host_model_i.start();
    sfp_host_model_i.bits({24'h0, op}, 8);
    sfp_host_model_i.bits({8'h0, a}, 24);
  endtask : frame

  task automatic prog(input logic [23:0] a, input logic [11:0] d, int n);
    frame(8'h02, a);
    sfp_host_model_i.bits({20'h0, d}, n);
    sfp_host_model_i.stop();
  endtask : prog

  task automatic ctl(input logic [7:0] op);
    sfp_host_model_i.start();
    sfp_host_model_i.bits({24'h0, op}, 8);
    sfp_host_model_i.stop();
  endtask : ctl

  task automatic core_set(input logic lock, clr, rdy);
    @(posedge core_clk);
    #1;
    sectorLock[1] = lock;
    clearFlags    = clr;
    memWrReady    = rdy;
  endtask : core_set

  task automatic wait_idle();
    for (int i = 0; i < 3000 && wip !== 1'b0; i++) @(posedge core_clk);
    cmp({7'h0, wip}, 8'h00, "done");
  endtask : wait_idle

  ////////////////////////////////////////
  // The start address crosses a 64KB line so the increment carries into address bit 16.
  task automatic t_read(input logic [7:0] op, input int dummy, lanes,
                        input logic [3:0] oe);
    sfp_host_model_i.lanes = lanes;
    frame(op, 24'h00FFFE);
    if (dummy > 0) sfp_host_model_i.bits(32'h0, dummy);
    for (int k = 0; k < 3; k++) begin
      sfp_host_model_i.bits(32'h0, 8 / lanes);
      cmp(sfp_host_model_i.rx, pat(32'h00FFFE + k), "read");
    end
    cmp({4'h0, dqOe}, {4'h0, oe}, "lane");
    sfp_host_model_i.stop();
    cmp({4'h0, dqOe}, 8'h00, "release");
  endtask : t_read

  task automatic t_prog();
    ctl(OP_WREN);
    cmp({7'h0, wel}, 8'h01, "wel set");
    frame(8'h02, 24'h0100FE);
    sfp_host_model_i.bits(32'h00112233, 24);
    sfp_host_model_i.stop();
    cmp({7'h0, wip}, 8'h01, "busy");
    ctl(8'h75);
    cmp(fsr, 8'h84, "suspend");
    cmp({7'h0, wip}, 8'h01, "suspend busy");
    ctl(8'h7A);
    cmp(fsr, 8'h00, "resumed");
    wait_idle();
    cmp(mem[17'h100FE], 8'h11, "byte0");
    cmp(mem[17'h100FF], 8'h22, "byte1");
    cmp(mem[17'h10000], 8'h33, "wrap");
    cmp(mem[17'h10001], pat(32'h10001), "kept");
    cmp(mem[17'h10100], pat(32'h10100), "next page");
    cmp({7'h0, wel}, 8'h00, "wel clear");
  endtask : t_prog

  // A partial byte, a locked sector and a stalled array in one sequence.
  task automatic t_faults();
    ctl(OP_WREN);
    prog(24'h010040, 12'hABC, 12);
    cmp({6'h0, wip, wel}, 8'h01, "bad end");
    cmp(fsr, 8'h80, "no flag");
    cmp(mem[17'h10040], pat(32'h10040), "no write");
    core_set(1'b1, 1'b0, 1'b1);
    prog(24'h010040, 12'h077, 8);
    cmp(fsr, 8'h92, "protect");
    cmp({6'h0, wip, wel}, 8'h01, "protect wel");
    core_set(1'b0, 1'b1, 1'b1);
    core_set(1'b0, 1'b0, 1'b0);
    cmp(fsr, 8'h80, "cleared");
    prog(24'h010040, 12'h077, 8);
    repeat (700) @(posedge core_clk);
    cmp({6'h0, fsr[FSR_PROG_FAIL], wel}, 8'h02, "timeout");
    core_set(1'b0, 1'b0, 1'b1);
    wait_idle();
  endtask : t_faults

  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #300000;
    err_count++;
    stop_test();
  end

  initial begin
    rstn       = 1'b0;
    clearFlags = 1'b0;
    memWrReady = 1'b1;
    sectorLock = '0;
    err_count  = 0;
    checks     = 0;
    for (int i = 0; i < 131072; i++) mem[i] = pat(i);
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    cmp(fsr, 8'h80, "reset status");
    cmp({2'h0, wip, wel, dqOe}, 8'h00, "reset idle");
    t_read(OP_READ, 0, 1, OE_SINGLE);
    t_read(OP_FAST, 8, 1, OE_SINGLE);
    t_read(OP_QOFR, 8, 4, OE_QUAD);
    t_read(OP_DOFR, 8, 2, OE_DUAL);
    sfp_host_model_i.lanes = 1;
    t_prog();
    t_faults();
    stop_test();
  end
endmodule : serial_flash_read_program_cmds_bench
